// *** hw/fic_device.sv ***
// flash device end: id, parameter table and register commands
`timescale 1ns/1ps
`default_nettype none
`include "fic_map.svh"
// Contract
// - param read: 5Ah, address, latency dummies
// - param bytes msb first on falling edge
// - param read starts at address, then sequential
// - host keeps param read at 133 MHz
// - host should use eight dummy cycles
// - quad mode: opcode and data on four lines
// - unique read 4Bh, 32 latency clocks
// - eight unique bytes, then undefined
// - latency cycles ignore data lines
// - 05h returns status one, repeating
// - host keeps quad status read 108 MHz
// - 07h returns status two, not quad
// - 35h 15h 33h return config registers
// - register write needs write enable first
// - nonvolatile write copies; volatile write alone
// - failed write sets error, stays busy
// - host writes reserved bits as zero
// - byte count at chip select selects registers
// - write starts at deselect, busy, clears latch
// - resets ignored during register write
// - protect bit plus low pin rejects writes
// - pin protection off in quad modes
// - 06h sets write enable latch
// - 30h clears busy, latch and errors
module fic_device
  import fic_pkg::*;
#(
  parameter int          NV_WRITE_CYC = `FIC_NV_WRITE_CYC,
  parameter logic [63:0] UNIQUE_ID    = 64'h0123_4567_89ab_cdef // arbitrary
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // software reset request and failure injection
  input  wire logic       soft_reset_req,
  input  wire logic       fail_inject,
  // parameter table drain
  output logic            tbl_req_valid,
  output logic [31:0]     tbl_req_addr,
  input  wire logic [7:0] tbl_data,
  // state
  output logic            busy,
  // link
  fic_link_if.dev         link
);
  // *****************************
  // pin synchronisers
  // *****************************
  logic [5:0] s1_q, s2_q;
  logic       sck_d1_q;
  always_ff @(posedge clk) begin
    s1_q     <= {link.cs_n, link.sck, link.io};
    s2_q     <= s1_q;
    sck_d1_q <= s2_q[4];
  end
  logic       cs_n, rise, fall;
  logic [3:0] io;
  logic       wp_n;
  assign cs_n = s2_q[5];
  assign io   = s2_q[3:0];
  assign wp_n = s2_q[2];
  assign rise = !cs_n && s2_q[4] && !sck_d1_q;
  assign fall = !cs_n && !s2_q[4] && sck_d1_q;
  // *****************************
  // registers
  // *****************************
  logic [7:0] sr1_q, sr2_q, cr1_q, cr2_q, cr3_q;
  logic [7:0] sr1_nv_q, cr1_nv_q, cr2_nv_q, cr3_nv_q;
  logic       quad;
  assign quad = cr2_q[`FIC_QPI_BIT];
  assign busy = sr1_q[`FIC_WIP_BIT];
  // *****************************
  // command decode
  // *****************************
  fic_state_t st_q;
  logic [7:0] sh_q;
  logic [7:0] op_q;
  logic [5:0] cnt_q;
  logic [5:0] dcnt_q;
  logic [31:0] addr_q;
  logic [4:0] wbytes_q;
  logic [31:0] wbuf_q;
  logic [7:0] out_q;
  logic [3:0] ubyte_q;
  logic [7:0] obyte;
  logic       oe_q;
  logic       cs_rise;
  logic       cs_q;
  logic       vol_sel_q;
  logic [2:0] step;
  logic [5:0] alen;
  assign step    = quad ? 3'd4 : 3'd1;
  assign alen    = cr2_q[`FIC_ADS_BIT] ? 6'd32 : 6'd24;
  assign cs_rise = cs_n && !cs_q;
  logic [7:0] nxt_sh;
  assign nxt_sh = quad ? {sh_q[3:0], io} : {sh_q[6:0], io[0]};
  // selected byte source for the current read command
  always_comb begin
    case (op_q)
      `FIC_OP_STAT1_READ: obyte = sr1_q;
      `FIC_OP_STAT2_READ: obyte = sr2_q;
      `FIC_OP_CONF1_READ: obyte = cr1_q;
      `FIC_OP_CONF2_READ: obyte = cr2_q;
      `FIC_OP_CONF3_READ: obyte = cr3_q;
      `FIC_OP_PARAM_READ: obyte = tbl_data;
      `FIC_OP_UNIQUE_READ: obyte = (ubyte_q < `FIC_UID_BYTES) ?
          UNIQUE_ID[63 - 8*ubyte_q[2:0] -: 8] : 8'h00;
      default: obyte = 8'h00;
    endcase
  end
  logic rd_ok;
  // status-two and config reads are not available in quad peripheral mode
  assign rd_ok = (op_q == `FIC_OP_STAT1_READ) || (op_q == `FIC_OP_PARAM_READ) ||
                 (op_q == `FIC_OP_UNIQUE_READ) || (!quad && (op_q == `FIC_OP_STAT2_READ ||
                 op_q == `FIC_OP_CONF1_READ || op_q == `FIC_OP_CONF2_READ ||
                 op_q == `FIC_OP_CONF3_READ));
  assign tbl_req_addr  = addr_q;
  assign tbl_req_valid = st_q == FIC_S_DATA && op_q == `FIC_OP_PARAM_READ;
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= FIC_S_OPCODE; sh_q <= '0; op_q <= '0; cnt_q <= '0; dcnt_q <= '0;
      addr_q <= '0; wbytes_q <= '0; wbuf_q <= '0; out_q <= '0; ubyte_q <= '0;
      oe_q <= 1'b0; cs_q <= 1'b1;
    end else begin
      cs_q <= cs_n;
      if (cs_n) begin
        st_q <= FIC_S_OPCODE; cnt_q <= '0; oe_q <= 1'b0; wbytes_q <= '0;
      end else if (rise) begin
        case (st_q)
          FIC_S_OPCODE: begin
            sh_q <= nxt_sh; cnt_q <= cnt_q + 6'(step);
            if (cnt_q + 6'(step) == 6'd8) begin
              op_q <= nxt_sh; cnt_q <= '0; addr_q <= '0; ubyte_q <= '0;
              if (nxt_sh == `FIC_OP_PARAM_READ) st_q <= FIC_S_ADDR;
              else if (nxt_sh == `FIC_OP_UNIQUE_READ) begin
                st_q <= FIC_S_DUMMY; dcnt_q <= `FIC_UID_LATENCY;
              end else if (nxt_sh == `FIC_OP_REG_WRITE) st_q <= FIC_S_WDATA;
              else st_q <= FIC_S_DATA;
            end
          end
          FIC_S_ADDR: begin
            addr_q <= quad ? {addr_q[27:0], io} : {addr_q[30:0], io[0]};
            cnt_q <= cnt_q + 6'(step);
            if (cnt_q + 6'(step) == alen) begin
              cnt_q <= '0; dcnt_q <= {2'b00, cr3_q[3:0]}; st_q <= FIC_S_DUMMY;
              if (cr3_q[3:0] == 4'd0) st_q <= FIC_S_DATA;
            end
          end
          FIC_S_DUMMY: begin
            // data lines are not sampled while counting latency
            dcnt_q <= dcnt_q - 6'd1;
            if (dcnt_q == 6'd1) st_q <= FIC_S_DATA;
          end
          FIC_S_WDATA: begin
            sh_q <= nxt_sh; cnt_q <= cnt_q + 6'(step);
            if (cnt_q + 6'(step) == 6'd8) begin
              cnt_q <= '0;
              wbuf_q <= {wbuf_q[23:0], nxt_sh};
              wbytes_q <= wbytes_q + 5'd1;
            end else if (cnt_q == 6'd0) begin
              wbytes_q <= wbytes_q | 5'h10; // mark partial byte
            end
          end
          // extra bits after a one-byte command spoil it
          FIC_S_DATA: if (!rd_ok) cnt_q <= 6'd1;
          default: st_q <= FIC_S_OPCODE;
        endcase
        if (st_q == FIC_S_WDATA && cnt_q + 6'(step) == 6'd8) wbytes_q[4] <= 1'b0;
      end else if (fall && st_q == FIC_S_DATA && rd_ok) begin
        // msb first, new byte each eight clocks on one line or each two in quad, fresh status every byte
        oe_q <= 1'b1;
        if (cnt_q == 6'd0) begin
          out_q <= obyte;
          ubyte_q <= ubyte_q + 4'd1;
          if (op_q == `FIC_OP_PARAM_READ) addr_q <= addr_q + 32'd1;
        end else begin
          out_q <= quad ? {out_q[3:0], 4'h0} : {out_q[6:0], 1'b0};
        end
        cnt_q <= (cnt_q + 6'(step) == 6'd8) ? 6'd0 : cnt_q + 6'(step);
      end
    end
  end
  assign link.io_dev_o  = quad ? out_q[7:4] : {2'b00, out_q[7], 1'b0};
  assign link.io_dev_oe = !oe_q ? 4'h0 : (quad ? 4'hf : 4'h2);
  // *****************************
  // write enables and self-timed write
  // *****************************
  fic_wstate_t ws_q;
  logic [15:0] wt_q;
  logic        whole, protect, go;
  logic [3:0]  nmask;
  assign whole   = cs_rise && wbytes_q[4] == 1'b0 && st_q == FIC_S_WDATA;
  assign protect = sr1_q[`FIC_SRP_BIT] && !wp_n &&
                   !cr1_q[`FIC_QUAD_BIT] && !quad;
  assign go = whole && op_q == `FIC_OP_REG_WRITE && ws_q == FIC_W_IDLE && !protect &&
              (sr1_q[`FIC_WEL_BIT] || vol_sel_q) &&
              wbytes_q[3:0] >= 4'd1 && wbytes_q[3:0] <= 4'd4;
  assign nmask = wbytes_q[3:0] == 4'd4 ? 4'b1111 : wbytes_q[3:0] == 4'd3 ? 4'b1110 :
                 wbytes_q[3:0] == 4'd2 ? 4'b1100 : 4'b1000;
  logic [31:0] wv;
  assign wv = wbytes_q[3:0] == 4'd4 ? wbuf_q : wbytes_q[3:0] == 4'd3 ? {wbuf_q[23:0], 8'h00} :
              wbytes_q[3:0] == 4'd2 ? {wbuf_q[15:0], 16'h0000} : {wbuf_q[7:0], 24'h0};
  logic [3:0]  pm_q;
  logic [31:0] pv_q;
  logic        pvol_q;
  logic        cmd8;
  assign cmd8 = cs_rise && st_q == FIC_S_DATA && cnt_q == 6'd0 && !oe_q;
  // soft_reset_req is ignored while a write runs
  always_ff @(posedge clk) begin
    if (rst && ws_q == FIC_W_IDLE || soft_reset_req && ws_q == FIC_W_IDLE) begin
      ws_q <= FIC_W_IDLE; wt_q <= '0; vol_sel_q <= 1'b0; pm_q <= '0; pv_q <= '0;
      pvol_q <= 1'b0;
      sr1_q <= sr1_nv_q; sr2_q <= '0; cr1_q <= cr1_nv_q; cr2_q <= cr2_nv_q;
      cr3_q <= cr3_nv_q;
      if (rst) begin
        sr1_q <= `FIC_SR1_RESET; cr1_q <= `FIC_CR1_RESET; cr2_q <= `FIC_CR2_RESET;
        cr3_q <= `FIC_CR3_RESET;
      end
    end else begin
      if (cmd8 && op_q == `FIC_OP_WRITE_ENABLE_CMD) sr1_q[`FIC_WEL_BIT] <= 1'b1;
      if (cmd8 && op_q == `FIC_OP_VOLATILE_WRITE_ENABLE_CMD) vol_sel_q <= 1'b1;
      if (whole) vol_sel_q <= 1'b0;
      case (ws_q)
        FIC_W_IDLE: if (go) begin
          ws_q <= FIC_W_BUSY; pm_q <= nmask; pv_q <= wv; pvol_q <= vol_sel_q;
          sr1_q[`FIC_WIP_BIT] <= 1'b1;
          wt_q <= vol_sel_q ? 16'(`FIC_V_WRITE_CYC) : 16'(NV_WRITE_CYC);
        end
        FIC_W_BUSY: begin
          wt_q <= wt_q - 16'd1;
          if (wt_q == 16'd1) begin
            if (fail_inject && !pvol_q) begin
              ws_q <= FIC_W_HUNG; sr2_q[`FIC_PERR_BIT] <= 1'b1;
            end else begin
              ws_q <= FIC_W_IDLE;
              sr1_q[`FIC_WIP_BIT] <= 1'b0; sr1_q[`FIC_WEL_BIT] <= 1'b0;
              if (pm_q[3]) sr1_q <= {pv_q[31:26], 2'b00};
              if (pm_q[2]) cr1_q <= pv_q[23:16];
              if (pm_q[1]) cr2_q <= pv_q[15:8];
              if (pm_q[0]) cr3_q <= pv_q[7:0];
            end
          end
        end
        FIC_W_HUNG: ;
        default: ws_q <= FIC_W_IDLE;
      endcase
      if (cmd8 && op_q == `FIC_OP_CLEAR_STAT) begin
        sr1_q[`FIC_WIP_BIT] <= 1'b0; sr1_q[`FIC_WEL_BIT] <= 1'b0;
        sr2_q[`FIC_PERR_BIT] <= 1'b0; sr2_q[`FIC_EERR_BIT] <= 1'b0;
        if (ws_q == FIC_W_HUNG) ws_q <= FIC_W_IDLE;
      end
    end
  end
  // nonvolatile copies only change from a write-enable directed write or from a reset while no write runs
  always_ff @(posedge clk) begin
    if (rst && ws_q == FIC_W_IDLE) begin
      sr1_nv_q <= `FIC_SR1_RESET; cr1_nv_q <= `FIC_CR1_RESET;
      cr2_nv_q <= `FIC_CR2_RESET; cr3_nv_q <= `FIC_CR3_RESET;
    end else if (ws_q == FIC_W_BUSY && wt_q == 16'd1 && !pvol_q && !fail_inject) begin
      if (pm_q[3]) sr1_nv_q <= {pv_q[31:26], 2'b00};
      if (pm_q[2]) cr1_nv_q <= pv_q[23:16];
      if (pm_q[1]) cr2_nv_q <= pv_q[15:8];
      if (pm_q[0]) cr3_nv_q <= pv_q[7:0];
    end
  end
endmodule
`default_nettype wire

// *** include/fic_map.svh ***
// opcodes, field positions, reset values and timing counts for the flash command block
`ifndef FIC_MAP_SVH
`define FIC_MAP_SVH
`define FIC_OP_PARAM_READ   8'h5a
`define FIC_OP_UNIQUE_READ  8'h4b
`define FIC_OP_STAT1_READ   8'h05
`define FIC_OP_STAT2_READ   8'h07
`define FIC_OP_CONF1_READ   8'h35
`define FIC_OP_CONF2_READ   8'h15
`define FIC_OP_CONF3_READ   8'h33
`define FIC_OP_REG_WRITE    8'h01
`define FIC_OP_WRITE_ENABLE_CMD         8'h06
`define FIC_OP_VOLATILE_WRITE_ENABLE_CMD        8'h50
`define FIC_OP_CLEAR_STAT   8'h30
`define FIC_UID_LATENCY     6'd32
`define FIC_UID_BYTES       4'd8
`define FIC_WIP_BIT         0
`define FIC_WEL_BIT         1
`define FIC_SRP_BIT         7
`define FIC_PERR_BIT        5
`define FIC_EERR_BIT        6
`define FIC_QUAD_BIT        1
`define FIC_QPI_BIT         3
`define FIC_ADS_BIT         0
`define FIC_SR1_RESET       8'h00
`define FIC_CR1_RESET       8'h00
`define FIC_CR2_RESET       8'h00
`define FIC_CR3_RESET       8'h08
`define FIC_NV_WRITE_NS     2000
`define FIC_NV_WRITE_CYC    ((`FIC_NV_WRITE_NS + 9) / 10)
`define FIC_V_WRITE_CYC     2
`define FIC_SCK_HALF_DIV    4'd3
`endif

// *** include/fic_pkg.sv ***
// types shared by both ends of the flash command link
package fic_pkg;
  typedef enum logic [4:0] {
    FIC_S_OPCODE  = 5'b00001,
    FIC_S_ADDR    = 5'b00010,
    FIC_S_DUMMY   = 5'b00100,
    FIC_S_DATA    = 5'b01000,
    FIC_S_WDATA   = 5'b10000
  } fic_state_t;
  typedef enum logic [2:0] {
    FIC_W_IDLE    = 3'b001,
    FIC_W_BUSY    = 3'b010,
    FIC_W_HUNG    = 3'b100
  } fic_wstate_t;
endpackage

// *** include/fic_link_if.sv ***
// serial link between host controller and flash device
`timescale 1ns/1ps
`default_nettype none
interface fic_link_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] io_host_o;
  logic [3:0] io_host_oe;
  logic [3:0] io_dev_o;
  logic [3:0] io_dev_oe;
  logic       wp_n;
  logic [3:0] io;
  genvar g;
  for (g = 0; g < 4; g++) begin : g_res
    assign io[g] = io_dev_oe[g] ? io_dev_o[g] :
                   io_host_oe[g] ? io_host_o[g] : (g == 2 ? wp_n : 1'b1);
  end
  modport dev  (input cs_n, sck, io, wp_n, output io_dev_o, io_dev_oe);
  modport host (output cs_n, sck, io_host_o, io_host_oe, wp_n, input io);
endinterface
`default_nettype wire

// *** hw/fic_fifo.sv ***
// small valid/ready fifo
`timescale 1ns/1ps
`default_nettype none
module fic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// *** hw/fic_host.sv ***
// host controller end: runs one command frame per request
`timescale 1ns/1ps
`default_nettype none
`include "fic_map.svh"
module fic_host
  import fic_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // request
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic [7:0] req_opcode,
  input  wire logic [3:0] req_tx_bytes,
  input  wire logic [7:0] req_tx_data,
  output logic            req_tx_take,
  input  wire logic [5:0] req_dummy,
  input  wire logic [4:0] req_rx_bytes,
  input  wire logic       req_quad,
  input  wire logic       wp_level,
  // answer
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  // link
  fic_link_if.host        link
);
  // *****************************
  // frame sequencing
  // *****************************
  // phase 0 opcode, 1 tx bytes, 2 dummy, 3 rx bytes
  logic [1:0] ph_q;
  logic       act_q;
  logic [3:0] div_q;
  logic       sck_q;
  logic [7:0] sh_q;
  logic [5:0] bit_q;
  logic [3:0] txn_q;
  logic [4:0] rxn_q;
  logic [5:0] dm_q;
  logic       quad_q;
  logic [7:0] op_q;
  logic       tick;
  logic       fall;
  logic       rise;
  logic [2:0] step;
  assign step      = quad_q ? 3'd4 : 3'd1;
  assign tick      = act_q && (div_q == `FIC_SCK_HALF_DIV);
  assign rise      = tick && !sck_q;
  assign fall      = tick && sck_q;
  assign req_ready = !act_q;
  assign req_tx_take = fall && ph_q == 2'd1 && bit_q == 6'd7 - 6'(step) + 6'd1 &&
                       txn_q > 4'd1;
  always_ff @(posedge clk) begin
    if (rst) begin
      act_q <= 1'b0; div_q <= '0; sck_q <= 1'b0; ph_q <= '0; bit_q <= '0;
      sh_q <= '0; txn_q <= '0; rxn_q <= '0; dm_q <= '0; quad_q <= 1'b0;
      op_q <= '0; rx_valid <= 1'b0; rx_data <= '0;
    end else begin
      rx_valid <= 1'b0;
      if (!act_q) begin
        if (req_valid) begin
          act_q <= 1'b1; ph_q <= 2'd0; sh_q <= req_opcode; bit_q <= '0;
          txn_q <= req_tx_bytes; rxn_q <= req_rx_bytes; dm_q <= req_dummy;
          quad_q <= req_quad; op_q <= req_opcode; div_q <= '0;
        end
      end else begin
        div_q <= tick ? 4'd0 : div_q + 4'd1;
        if (tick) sck_q <= !sck_q;
        if (rise) begin
          if (ph_q == 2'd3) begin
            sh_q <= quad_q ? {sh_q[3:0], link.io} : {sh_q[6:0], link.io[1]};
          end
          bit_q <= bit_q + 6'(step);
        end
        if (fall) begin
          if (ph_q == 2'd0 || ph_q == 2'd1) begin
            sh_q <= quad_q ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
          end
          if (ph_q == 2'd3 && bit_q == 6'd8) begin
            rx_valid <= 1'b1; rx_data <= sh_q;
          end
          if (bit_q == 6'd8 && ph_q < 2'd2) begin
            bit_q <= '0;
            if (ph_q == 2'd1) txn_q <= txn_q - 4'd1;
            if (ph_q == 2'd0 && txn_q != 4'd0) ph_q <= 2'd1;
            else if (ph_q == 2'd1 && txn_q > 4'd1) sh_q <= req_tx_data;
            else ph_q <= 2'd2;
            if (ph_q == 2'd0 && txn_q != 4'd0) sh_q <= req_tx_data;
            if ((ph_q == 2'd0 && txn_q == 4'd0 || ph_q == 2'd1 && txn_q == 4'd1) &&
                dm_q == 6'd0) ph_q <= 2'd3;
            if ((ph_q == 2'd0 && txn_q == 4'd0 || ph_q == 2'd1 && txn_q == 4'd1) &&
                dm_q == 6'd0 && rxn_q == 5'd0) act_q <= 1'b0;
          end else if (ph_q == 2'd2 && bit_q != 6'd0) begin
            bit_q <= '0;
            dm_q <= dm_q - 6'd1;
            if (dm_q == 6'd1) ph_q <= 2'd3;
            if (dm_q == 6'd1 && rxn_q == 5'd0) act_q <= 1'b0;
          end else if (ph_q == 2'd3 && bit_q == 6'd8) begin
            bit_q <= '0;
            rxn_q <= rxn_q - 5'd1;
            if (rxn_q == 5'd1) act_q <= 1'b0;
          end
        end
      end
    end
  end
  // *****************************
  // pins
  // *****************************
  // host keeps sck at or under the per-command limits through the divider
  logic drive;
  assign drive           = act_q && ph_q < 2'd2;
  assign link.cs_n       = !act_q;
  assign link.sck        = sck_q;
  assign link.wp_n       = wp_level;
  // receive shifting must not show on the undriven output lines
  assign link.io_host_o  = !drive ? 4'h0 : (quad_q ? sh_q[7:4] : {3'b000, sh_q[7]});
  assign link.io_host_oe = !drive ? 4'h0 : (quad_q ? 4'hf : 4'h1);
endmodule
`default_nettype wire

// *** verification/fic_link_properties.sv ***
// wire-level properties of the flash command link
`timescale 1ns/1ps
`default_nettype none
module fic_link_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // link signals
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] io_host_o,
  input wire logic [3:0] io_host_oe,
  input wire logic [3:0] io_dev_o,
  input wire logic [3:0] io_dev_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ***********
  // frame steps
  // ***********
  sequence s_select;
    $fell(cs_n);
  endsequence
  sequence s_dev_quiet;
    (io_dev_oe == 4'h0) [*8];
  endsequence
  sequence s_clock_high;
    sck [*4];
  endsequence
  AST_OPCODE_QUIET: assert property (s_select |-> s_dev_quiet)
    else $error("device drove during the opcode");
  AST_NO_FIGHT: assert property ((io_dev_oe & io_host_oe) == 4'h0)
    else $error("both ends drive one line");
  AST_DEV_RELEASE: assert property (cs_n && $past(cs_n, 4) |-> io_dev_oe == 4'h0)
    else $error("device drives while deselected");
  AST_DEV_WIDTH: assert property (|io_dev_oe |-> io_dev_oe inside {4'h2, 4'hf})
    else $error("device drives an odd set of lines");
  AST_SCK_IDLE: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("clock moves outside a frame");
  AST_SCK_RATE: assert property ($rose(sck) |-> s_clock_high)
    else $error("clock high phase too short");
  AST_DEV_ON_FALL: assert property (!cs_n && |io_dev_oe && $changed(io_dev_o) |-> !sck)
    else $error("device data moved while clock high");
  AST_HOST_HOLD: assert property ($rose(sck) |-> $stable(io_host_o) [*4])
    else $error("host data moved while clock high");
endmodule
`default_nettype wire

// *** verification/flash_id_and_register_commands_tb.sv ***
// self-checking bench for both ends of the flash command link
`timescale 1ns/1ps
`default_nettype none
`include "fic_map.svh"
module flash_id_and_register_commands_tb;
  localparam int          NV_CYC = 600;
  localparam logic [63:0] UID    = 64'h1122_3344_5566_7788; // arbitrary
  logic       clk, rst, req_valid, req_ready, req_tx_take, req_quad, wp_level;
  logic       rx_valid, busy, soft_reset_req, fail_inject, in_ready, out_valid;
  logic       out_ready, drain, tbl_req_valid;
  logic [7:0] req_opcode, req_tx_data, rx_data, tbl_data, out_data, lfsr, want;
  logic [3:0] req_tx_bytes;
  logic [5:0] req_dummy;
  logic [4:0] req_rx_bytes;
  logic [31:0] tx_w, tbl_req_addr;
  logic [23:0] a;
  logic [1:0] tx_idx;
  logic [7:0] exp_q[$];
  int         errors, n_checks, cyc;
  fic_link_if link ();
  fic_host u_fic_host (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_opcode(req_opcode), .req_tx_bytes(req_tx_bytes), .req_tx_data(req_tx_data),
    .req_tx_take(req_tx_take), .req_dummy(req_dummy), .req_rx_bytes(req_rx_bytes),
    .req_quad(req_quad), .wp_level(wp_level), .rx_valid(rx_valid), .rx_data(rx_data),
    .link(link));
  fic_device #(.NV_WRITE_CYC(NV_CYC), .UNIQUE_ID(UID)) u_fic_device (.clk(clk), .rst(rst),
    .soft_reset_req(soft_reset_req), .fail_inject(fail_inject), .tbl_req_valid(tbl_req_valid),
    .tbl_req_addr(tbl_req_addr), .tbl_data(tbl_data), .busy(busy), .link(link));
  fic_fifo #(.WIDTH(8), .DEPTH(16)) u_fic_fifo (.clk(clk), .rst(rst), .in_valid(rx_valid),
    .in_ready(in_ready), .in_data(rx_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data));
  fic_link_properties u_fic_link_properties (.clk(clk), .rst(rst), .cs_n(link.cs_n),
    .sck(link.sck), .io_host_o(link.io_host_o), .io_host_oe(link.io_host_oe),
    .io_dev_o(link.io_dev_o), .io_dev_oe(link.io_dev_oe));
  // *************
  // drive helpers
  // *************
  assign req_tx_data = tx_w[8*(3-tx_idx) +: 8];
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  always @(posedge clk) begin
    lfsr      <= nx(lfsr);
    out_ready <= drain & lfsr[0];
    tbl_data  <= tbl_req_valid ? (tbl_req_addr[7:0] ^ 8'ha5) : 8'h00;
    if (req_tx_take) tx_idx <= tx_idx + 2'd1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      end_of_test;
    end
  end
  task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: byte %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_l(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: level %b want %b", $time, g, e);
    end
  endtask
  // one frame; the host owns the link until deselect and idle
  task automatic cmd(input logic [7:0] op, input logic [3:0] nt, input logic [31:0] w,
                     input logic [5:0] dm, input logic [4:0] nr);
    @(posedge clk);
    tx_w         <= w;
    tx_idx       <= 2'd0;
    req_opcode   <= op;
    req_tx_bytes <= nt;
    req_dummy    <= dm;
    req_rx_bytes <= nr;
    req_valid    <= 1'b1;
    @(posedge clk);
    while (!req_ready) @(posedge clk);
    req_valid <= 1'b0;
    repeat (4) @(posedge clk);
    while (!(link.cs_n && req_ready)) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] op, input logic [63:0] v, input int n,
                    input logic [5:0] dm = 6'd0);
    for (int i = n - 1; i >= 0; i--) exp_q.push_back(v[8*i +: 8]);
    cmd(op, 4'd0, 32'h0, dm, 5'(n));
  endtask
  task automatic wr(input logic [7:0] en, input logic [3:0] n, input logic [31:0] w);
    cmd(en, 4'd0, 32'h0, 6'd0, 5'd0);
    cmd(`FIC_OP_REG_WRITE, n, w, 6'd0, 5'd0);
  endtask
  task automatic pr(input logic [3:0] nt, input int nr);
    for (int i = 0; i < nr; i++) exp_q.push_back(8'(a + 24'(i)) ^ 8'ha5);
    cmd(`FIC_OP_PARAM_READ, nt, (nt == 4'd3) ? {a, 8'h00} : {8'h00, a}, 6'd8, 5'(nr));
  endtask
  task automatic settle;
    for (int k = 0; k < 3000 && (exp_q.size() != 0 || out_valid); k++) @(posedge clk);
  endtask
  task automatic end_of_test;
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    if (!rst && out_valid && out_ready) begin
      want = 8'hxx;
      if (exp_q.size() > 0) want = exp_q.pop_front();
      chk_b(out_data, want);
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ********
  // sequence
  // ********
  initial begin
    {rst, drain, wp_level, lfsr} = {3'b111, 8'h5f};
    {req_valid, req_quad, soft_reset_req, fail_inject, out_ready} = 5'h0;
    {req_opcode, req_tx_bytes, req_dummy, req_rx_bytes, tx_w, tx_idx} = '0;
    {tbl_data, errors, n_checks, cyc} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`FIC_OP_STAT1_READ, `FIC_SR1_RESET, 2);
    rd(`FIC_OP_STAT2_READ, 8'h00, 1);
    rd(`FIC_OP_CONF1_READ, `FIC_CR1_RESET, 1);
    rd(`FIC_OP_CONF2_READ, `FIC_CR2_RESET, 1);
    rd(`FIC_OP_CONF3_READ, `FIC_CR3_RESET, 1);
    rd(`FIC_OP_UNIQUE_READ, UID, 8, 6'(`FIC_UID_LATENCY));
    // stalled drain: sixteen table bytes fill the fifo until it refuses
    settle;
    drain <= 1'b0;
    a = {8'h00, lfsr, 8'hf8};
    pr(4'd3, 16);
    chk_l(in_ready, 1'b0);
    drain <= 1'b1;
    cmd(`FIC_OP_REG_WRITE, 4'd1, 32'h1c00_0000, 6'd0, 5'd0);
    rd(`FIC_OP_STAT1_READ, 8'h00, 1);
    wr(`FIC_OP_VOLATILE_WRITE_ENABLE_CMD, 4'd3, 32'h1c00_0100);
    rd(`FIC_OP_CONF2_READ, 8'h01, 1);
    wr(`FIC_OP_VOLATILE_WRITE_ENABLE_CMD, 4'd1, 32'h0);
    rd(`FIC_OP_STAT1_READ, 8'h00, 1);
    rd(`FIC_OP_CONF2_READ, 8'h01, 1);
    pr(4'd4, 2);
    cmd(`FIC_OP_WRITE_ENABLE_CMD, 4'd0, 32'h0, 6'd0, 5'd0);
    rd(`FIC_OP_STAT1_READ, 8'h02, 1);
    cmd(`FIC_OP_REG_WRITE, 4'd1, 32'h1c00_0000, 6'd0, 5'd0);
    chk_l(busy, 1'b1);
    rd(`FIC_OP_STAT1_READ, 8'h03, 1);
    settle;
    {rst, soft_reset_req} <= 2'b11;
    repeat (2) @(posedge clk);
    {rst, soft_reset_req} <= 2'b00;
    @(posedge clk);
    chk_l(busy, 1'b1);
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clk);
    rd(`FIC_OP_STAT1_READ, 8'h1c, 1);
    soft_reset_req <= 1'b1;
    @(posedge clk);
    soft_reset_req <= 1'b0;
    rd(`FIC_OP_CONF2_READ, 8'h00, 1);
    fail_inject <= 1'b1;
    wr(`FIC_OP_WRITE_ENABLE_CMD, 4'd1, 32'h1c00_0000);
    repeat (NV_CYC + 100) @(posedge clk);
    chk_l(busy, 1'b1);
    rd(`FIC_OP_STAT2_READ, 8'h20, 1);
    fail_inject <= 1'b0;
    cmd(`FIC_OP_CLEAR_STAT, 4'd0, 32'h0, 6'd0, 5'd0);
    chk_l(busy, 1'b0);
    rd(`FIC_OP_STAT2_READ, 8'h00, 1);
    wr(`FIC_OP_VOLATILE_WRITE_ENABLE_CMD, 4'd1, 32'h8000_0000);
    wp_level <= 1'b0;
    wr(`FIC_OP_VOLATILE_WRITE_ENABLE_CMD, 4'd1, 32'h0);
    rd(`FIC_OP_STAT1_READ, 8'h80, 1);
    wp_level <= 1'b1;
    wr(`FIC_OP_VOLATILE_WRITE_ENABLE_CMD, 4'd2, 32'h8002_0000);
    wp_level <= 1'b0;
    wr(`FIC_OP_VOLATILE_WRITE_ENABLE_CMD, 4'd1, 32'h0);
    rd(`FIC_OP_STAT1_READ, 8'h00, 1);
    wp_level <= 1'b1;
    wr(`FIC_OP_VOLATILE_WRITE_ENABLE_CMD, 4'd3, 32'h0000_0800);
    req_quad <= 1'b1;
    rd(`FIC_OP_STAT1_READ, 8'h00, 1);
    rd(`FIC_OP_UNIQUE_READ, UID, 8, 6'(`FIC_UID_LATENCY));
    settle;
    chk_l(exp_q.size() == 0, 1'b1);
    end_of_test;
  end
endmodule
`default_nettype wire
